// >>> inc/tsiu_cfg.svh
// constants of the three source interrupt unit
`ifndef TSIU_CFG_SVH
`define TSIU_CFG_SVH
`define TSIU_CLK_PERIOD_NS 40
`define TSIU_VEC_EXT 8'h04
`define TSIU_VEC_TMR 8'h08
`define TSIU_VEC_CONV 8'h0c
`define TSIU_OFF_CTRL 32'h00000000
`define TSIU_OFF_STAT 32'h00000004
`define TSIU_OFF_CORE 32'h00000008
`define TSIU_BIT_GIE 0
`define TSIU_BIT_EXT_EN 1
`define TSIU_BIT_TMR_EN 2
`define TSIU_BIT_CONV_EN 3
`define TSIU_BIT_EXT_FLAG 4
`define TSIU_BIT_TMR_FLAG 5
`define TSIU_BIT_CONV_FLAG 6
`define TSIU_CTRL_RESET 7'h00
`define TSIU_BIT_DIR5 0
`define TSIU_BIT_PULLUP 1
`define TSIU_BIT_STACK_FULL 0
`define TSIU_BIT_POWERDOWN 1
`define TSIU_BIT_PIN 2
`endif

// >>> inc/tsiu_pkg.sv
// types of the three source interrupt unit
`default_nettype none
package tsiu_pkg;
	typedef enum logic [1:0] {
		TSIU_SRC_NONE = 2'h0,
		TSIU_SRC_EXT  = 2'h1,
		TSIU_SRC_TMR  = 2'h2,
		TSIU_SRC_CONV = 2'h3
	} tsiu_src_type;
	typedef enum logic [1:0] {
		TSIU_ST_IDLE = 2'h0,
		TSIU_ST_WAIT = 2'h1,
		TSIU_ST_ACK  = 2'h2
	} tsiu_state_type;
endpackage : tsiu_pkg
`default_nettype wire

// >>> hw/tsiu_edge.sv
// falling edge detector for the shared port line
`default_nettype none
`include "tsiu_cfg.svh"
module tsiu_edge
	import tsiu_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// line
	input  wire logic line_i,
	input  wire logic arm_i,
	output logic      fall_o
);
	logic last;
	// reset value high, so a line that is low at release is taken as a falling edge
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last <= 1'b1;
		end else begin
			last <= line_i;
		end
	end
	assign fall_o = arm_i & last & ~line_i; // [R2] [R3]
endmodule // tsiu_edge
`default_nettype wire

// >>> hw/tsiu_arb.sv
// fixed priority arbiter and vector lookup
`default_nettype none
`include "tsiu_cfg.svh"
module tsiu_arb
	import tsiu_pkg::*;
(
	// requests
	input  wire logic [2:0] req_i,
	// choice
	output tsiu_src_type    src_o,
	output logic [7:0]      vec_o
);
	function automatic logic [7:0] vec_of(input tsiu_src_type s);
		case (s)
			TSIU_SRC_EXT: vec_of = `TSIU_VEC_EXT; // [R4]
			TSIU_SRC_TMR: vec_of = `TSIU_VEC_TMR; // [R8]
			TSIU_SRC_CONV: vec_of = `TSIU_VEC_CONV; // [R11]
			default: vec_of = 8'h00;
		endcase
	endfunction
	assign src_o = req_i[0] ? TSIU_SRC_EXT : req_i[1] ? TSIU_SRC_TMR : // [R17]
		req_i[2] ? TSIU_SRC_CONV : TSIU_SRC_NONE;
	assign vec_o = vec_of(src_o);
endmodule // tsiu_arb
`default_nettype wire

// >>> hw/tsiu_top.sv
// three source interrupt unit with AXI4-Lite register slave
// What this block does
// [R1] external serviced only with global and own enable
// [R2] falling edge on pin sets external flag
// [R3] pin counts only if enabled and input
// [R4] external entry pushes pc, vector 04h
// [R5] external service clears its flag and global
// [R6] pull-high option stays on as interrupt
// [R7] timer overflow sets flag; needs both enables
// [R8] timer entry pushes pc, vector 08h
// [R9] timer service clears its flag and global
// [R10] conversion done sets flag; needs both enables
// [R11] converter entry pushes pc, vector 0ch
// [R12] converter service clears its flag and global
// [R13] flags stay set until serviced or cleared
// [R14] any source wakes core from power down
// [R15] only program counter pushed on entry
// [R16] all interrupts disabled after reset
// [R17] priority external, timer, then converter
// [R18] requests taken on next phase two pulse
// [R19] flags still recorded while global cleared
// [R20] no acknowledge while stack is full
// [R21] software writes act next cycle, withdraw
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
`include "tsiu_cfg.svh"
module tsiu_top
	import tsiu_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RESET_N_I,
	// axi4-lite write address
	input  wire logic [31:0] S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	// axi4-lite write data
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	// axi4-lite write response
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	// axi4-lite read address
	input  wire logic [31:0] S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	// axi4-lite read data
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	// event sources
	input  wire logic        PORT_A_LINE_FIVE_I,
	input  wire logic        TIMER_OVERFLOW_I,
	input  wire logic        CONV_DONE_I,
	// core side
	input  wire logic        PHASE_TWO_PULSE_I,
	input  wire logic        STACK_FULL_I,
	input  wire logic        POWER_DOWN_I,
	output logic             IRQ_ENTRY_O,
	output logic [7:0]       IRQ_VECTOR_O,
	output logic             PUSH_PC_O,
	output logic             WAKE_O,
	output logic             PORT_A_PULL_HIGH_O
);
	// ****************************************************************
	// control state
	// ****************************************************************
	logic        global_irq_enable;
	logic        ext_pin_irq_enable;
	logic        timer_irq_enable;
	logic        conv_irq_enable;
	logic        ext_pin_irq_flag;
	logic        timer_overflow_flag;
	logic        conv_done_flag;
	logic        port_a_dir_bit_five;
	logic        pull_high_opt;
	logic [7:0]  vector;
	logic        entry;
	logic        wake;

	// ****************************************************************
	// bus slave
	// ****************************************************************
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        rvalid;
	logic [1:0]  rresp;
	logic [31:0] rdata;

	// registers are picked by word index, so the two low address bits never matter
	function automatic logic off_hit(input logic [31:0] addr, input logic [31:0] off);
		off_hit = addr[31:2] == off[31:2];
	endfunction

	wire         aw_take = S_AXI_AWVALID_I & ~aw_held & ~bvalid;
	wire         w_take = S_AXI_WVALID_I & ~w_held & ~bvalid;
	wire         aw_have = aw_held | aw_take;
	wire         w_have = w_held | w_take;
	wire         wr_fire = aw_have & w_have & ~bvalid;
	wire  [31:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR_I;
	wire  [31:0] wr_data = w_held ? w_data : S_AXI_WDATA_I;
	wire  [3:0]  wr_strb = w_held ? w_strb : S_AXI_WSTRB_I;
	wire         wr_ctrl = wr_fire & off_hit(wr_addr, `TSIU_OFF_CTRL) & wr_strb[0];
	wire         wr_core = wr_fire & off_hit(wr_addr, `TSIU_OFF_CORE) & wr_strb[0];
	wire         wr_ok = off_hit(wr_addr, `TSIU_OFF_CTRL) | off_hit(wr_addr, `TSIU_OFF_CORE);
	wire         ar_take = S_AXI_ARVALID_I & ~rvalid;
	wire         rd_ctrl = off_hit(S_AXI_ARADDR_I, `TSIU_OFF_CTRL);
	wire         rd_stat = off_hit(S_AXI_ARADDR_I, `TSIU_OFF_STAT);
	wire         rd_core = off_hit(S_AXI_ARADDR_I, `TSIU_OFF_CORE);
	wire  [6:0]  ctrl_word = {conv_done_flag, timer_overflow_flag, ext_pin_irq_flag,
		conv_irq_enable, timer_irq_enable, ext_pin_irq_enable, global_irq_enable};
	wire  [2:0]  stat_word = {PORT_A_LINE_FIVE_I, POWER_DOWN_I, STACK_FULL_I};
	wire  [31:0] next_rdata = rd_ctrl ? {25'h0000000, ctrl_word} :
		rd_stat ? {29'h00000000, stat_word} :
		rd_core ? {30'h00000000, pull_high_opt, port_a_dir_bit_five} : 32'h00000000;

	assign S_AXI_AWREADY_O = ~aw_held & ~bvalid;
	assign S_AXI_WREADY_O = ~w_held & ~bvalid;
	assign S_AXI_ARREADY_O = ~rvalid;
	assign S_AXI_BVALID_O = bvalid;
	assign S_AXI_BRESP_O = bresp;
	assign S_AXI_RVALID_O = rvalid;
	assign S_AXI_RRESP_O = rresp;
	assign S_AXI_RDATA_O = rdata;

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else begin
			if (aw_take & ~wr_fire) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR_I;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (w_take & ~wr_fire) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (S_AXI_BREADY_I) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h00000000;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rresp <= (rd_ctrl | rd_stat | rd_core) ? 2'h0 : 2'h2;
			rdata <= next_rdata;
		end else if (S_AXI_RREADY_I) begin
			rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// request detection and arbitration
	// ****************************************************************
	logic         ext_fall;
	tsiu_src_type pick;
	logic [7:0]   pick_vec;

	// the pin only arms as interrupt input when enabled and set as input
	wire          pin_armed = ext_pin_irq_enable & port_a_dir_bit_five; // [R3]

	tsiu_edge u_edge (
		.clk_i     (MCLK_I),
		.reset_n_i (RESET_N_I),
		.line_i    (PORT_A_LINE_FIVE_I),
		.arm_i     (pin_armed),
		.fall_o    (ext_fall)
	);

	wire  [2:0]   pending = {conv_done_flag & conv_irq_enable, // [R10]
		timer_overflow_flag & timer_irq_enable, // [R7]
		ext_pin_irq_flag & ext_pin_irq_enable}; // [R1]

	tsiu_arb u_arb (
		.req_i (pending),
		.src_o (pick),
		.vec_o (pick_vec)
	);

	// stack full holds every request back until the core pops
	wire          take = PHASE_TWO_PULSE_I & global_irq_enable & ~STACK_FULL_I & (pick != TSIU_SRC_NONE); // [R18] [R20]
	wire          clr_ext = take & (pick == TSIU_SRC_EXT); // [R5]
	wire          clr_tmr = take & (pick == TSIU_SRC_TMR); // [R9]
	wire          clr_conv = take & (pick == TSIU_SRC_CONV); // [R12]

	// set wins over both software and service clears
	wire [6:0]    next_ctrl_sw = wr_ctrl ? wr_data[6:0] : ctrl_word; // [R21]
	wire          next_ext_flag = ext_fall | (next_ctrl_sw[`TSIU_BIT_EXT_FLAG] & ~clr_ext); // [R2] [R13] [R19]
	wire          next_tmr_flag = TIMER_OVERFLOW_I | (next_ctrl_sw[`TSIU_BIT_TMR_FLAG] & ~clr_tmr); // [R7] [R13]
	wire          next_conv_flag = CONV_DONE_I | (next_ctrl_sw[`TSIU_BIT_CONV_FLAG] & ~clr_conv); // [R10] [R13]
	wire          next_gie = next_ctrl_sw[`TSIU_BIT_GIE] & ~take; // [R5] [R9] [R12]

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			{conv_done_flag, timer_overflow_flag, ext_pin_irq_flag, conv_irq_enable,
				timer_irq_enable, ext_pin_irq_enable, global_irq_enable} <= `TSIU_CTRL_RESET; // [R16]
		end else begin
			global_irq_enable <= next_gie;
			ext_pin_irq_enable <= next_ctrl_sw[`TSIU_BIT_EXT_EN];
			timer_irq_enable <= next_ctrl_sw[`TSIU_BIT_TMR_EN];
			conv_irq_enable <= next_ctrl_sw[`TSIU_BIT_CONV_EN];
			ext_pin_irq_flag <= next_ext_flag;
			timer_overflow_flag <= next_tmr_flag;
			conv_done_flag <= next_conv_flag;
		end
	end

	// port direction resets to input like the port register itself
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			port_a_dir_bit_five <= 1'b1;
			pull_high_opt <= 1'b0;
		end else if (wr_core) begin
			port_a_dir_bit_five <= wr_data[`TSIU_BIT_DIR5];
			pull_high_opt <= wr_data[`TSIU_BIT_PULLUP];
		end
	end

	// ****************************************************************
	// core handshake
	// ****************************************************************
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			entry <= 1'b0;
			vector <= 8'h00;
			wake <= 1'b0;
		end else begin
			entry <= take; // [R4] [R8] [R11]
			if (take) begin
				vector <= pick_vec;
			end
			// wake ignores the global enable, as a halted core must restart to service
			wake <= POWER_DOWN_I & (pending != 3'h0); // [R14]
		end
	end

	assign IRQ_ENTRY_O = entry;
	assign IRQ_VECTOR_O = vector;
	assign PUSH_PC_O = entry; // [R15]
	// pull-high option is independent of the interrupt arming
	assign PORT_A_PULL_HIGH_O = pull_high_opt; // [R6]
	assign WAKE_O = wake;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_vec_ext;
		@(posedge MCLK_I) disable iff (!RESET_N_I) take & pending[0] |=> IRQ_ENTRY_O & (IRQ_VECTOR_O == 8'h04);
	endproperty
	a_vec_ext: assert property (p_vec_ext) else $error("external vector wrong"); // [R4] [R17]
	property p_vec_tmr;
		@(posedge MCLK_I) disable iff (!RESET_N_I) take & pending == 3'h2 |=> IRQ_VECTOR_O == 8'h08;
	endproperty
	a_vec_tmr: assert property (p_vec_tmr) else $error("timer vector wrong"); // [R8]
	property p_vec_conv;
		@(posedge MCLK_I) disable iff (!RESET_N_I) take & pending == 3'h4 |=> IRQ_VECTOR_O == 8'h0c;
	endproperty
	a_vec_conv: assert property (p_vec_conv) else $error("converter vector wrong"); // [R11]
	property p_gie_off;
		@(posedge MCLK_I) disable iff (!RESET_N_I) IRQ_ENTRY_O |-> !global_irq_enable;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("global enable kept on entry"); // [R5] [R9] [R12]
	property p_full;
		@(posedge MCLK_I) disable iff (!RESET_N_I) $past(STACK_FULL_I) |-> !IRQ_ENTRY_O;
	endproperty
	a_full: assert property (p_full) else $error("entry with full stack"); // [R20]
	property p_phase;
		@(posedge MCLK_I) disable iff (!RESET_N_I) IRQ_ENTRY_O |-> $past(PHASE_TWO_PULSE_I) & $past(global_irq_enable);
	endproperty
	a_phase: assert property (p_phase) else $error("entry off phase two"); // [R18] [R1]
	property p_hold;
		@(posedge MCLK_I) disable iff (!RESET_N_I) ext_pin_irq_flag & !wr_ctrl & !clr_ext |=> ext_pin_irq_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost"); // [R13]
	property p_edge;
		@(posedge MCLK_I) disable iff (!RESET_N_I) pin_armed & $fell(PORT_A_LINE_FIVE_I) |=> ext_pin_irq_flag;
	endproperty
	a_edge: assert property (p_edge) else $error("edge not recorded"); // [R2] [R19]
	property p_wake;
		@(posedge MCLK_I) disable iff (!RESET_N_I) POWER_DOWN_I & timer_overflow_flag & timer_irq_enable |=> WAKE_O;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // [R14]
	property p_wake_off;
		@(posedge MCLK_I) disable iff (!RESET_N_I) !POWER_DOWN_I |=> !WAKE_O;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake while running"); // [R14]
	property p_clr_ext;
		@(posedge MCLK_I) disable iff (!RESET_N_I) clr_ext & !ext_fall |=> !ext_pin_irq_flag;
	endproperty
	a_clr_ext: assert property (p_clr_ext) else $error("external flag kept after service"); // [R5]
	property p_clr_tmr;
		@(posedge MCLK_I) disable iff (!RESET_N_I) clr_tmr & !TIMER_OVERFLOW_I |=> !timer_overflow_flag;
	endproperty
	a_clr_tmr: assert property (p_clr_tmr) else $error("timer flag kept after service"); // [R9]
	property p_clr_conv;
		@(posedge MCLK_I) disable iff (!RESET_N_I) clr_conv & !CONV_DONE_I |=> !conv_done_flag;
	endproperty
	a_clr_conv: assert property (p_clr_conv) else $error("converter flag kept after service"); // [R12]
	property p_arm;
		@(posedge MCLK_I) disable iff (!RESET_N_I) !pin_armed & !ext_pin_irq_flag & !wr_ctrl |=> !ext_pin_irq_flag;
	endproperty
	a_arm: assert property (p_arm) else $error("external flag set while pin unarmed"); // [R3]
	property p_sw_en;
		@(posedge MCLK_I) disable iff (!RESET_N_I) wr_ctrl |=> ext_pin_irq_enable == $past(wr_data[`TSIU_BIT_EXT_EN]);
	endproperty
	a_sw_en: assert property (p_sw_en) else $error("enable write not applied"); // [R21]
	property p_one_entry;
		@(posedge MCLK_I) disable iff (!RESET_N_I) IRQ_ENTRY_O |=> !IRQ_ENTRY_O;
	endproperty
	a_one_entry: assert property (p_one_entry) else $error("second entry without global enable"); // [R5] [R19]
	c_ext: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) take & pick == TSIU_SRC_EXT);
	c_conv: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) take & pick == TSIU_SRC_CONV);
	c_both: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) take & pending == 3'h3);
	c_wake: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) WAKE_O);
	c_full: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I)
		PHASE_TWO_PULSE_I & global_irq_enable & STACK_FULL_I & (pending != 3'h0));
endmodule // tsiu_top
`default_nettype wire

// >>> bench/tsiu_core_model.sv
// core model: phase two pulses and a small return stack
`default_nettype none
module tsiu_core_model #(
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// entry and return
	input  wire logic push_i,
	input  wire logic ret_i,
	// to the unit
	output logic      phase_o,
	output logic      full_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase;
	logic [3:0] depth;
	// a pulse only every fourth cycle, so requests must wait for it
	assign phase_o = phase == 2'h3;
	assign full_o = depth == 4'(DEPTH);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase <= 2'h0;
			depth <= 4'h0;
		end else begin
			phase <= phase + 2'h1;
			depth <= depth + 4'(push_i) - 4'(ret_i);
		end
	end
endmodule // tsiu_core_model
`default_nettype wire

// >>> bench/tsiu_top_bench.sv
// self-checking bench of the three source interrupt unit
`default_nettype none
`include "tsiu_cfg.svh"
module tsiu_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// signals
	// ****************
	localparam logic [31:0] CT = `TSIU_OFF_CTRL;
	localparam logic [31:0] CO = `TSIU_OFF_CORE;
	logic [7:0]  vtab [3] = '{`TSIU_VEC_EXT, `TSIU_VEC_TMR, `TSIU_VEC_CONV};
	logic        clk = 1'h0, rst_n = 1'h0, pin = 1'h1, tov = 1'h0, cdn = 1'h0, pdn = 1'h0, ret = 1'h0;
	logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic        awr, wrdy, bv, arr, rv, ent_o, push, wake, pull, phase, full;
	logic [1:0]  bresp, rresp;
	logic [7:0]  vec, seed = 8'h26;
	int          mismatches = 0, comparisons = 0;
	always #20 clk = ~clk;
	tsiu_top tsiu_top_i (
		.MCLK_I(clk), .RESET_N_I(rst_n),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
		.PORT_A_LINE_FIVE_I(pin), .TIMER_OVERFLOW_I(tov), .CONV_DONE_I(cdn),
		.PHASE_TWO_PULSE_I(phase), .STACK_FULL_I(full), .POWER_DOWN_I(pdn),
		.IRQ_ENTRY_O(ent_o), .IRQ_VECTOR_O(vec), .PUSH_PC_O(push), .WAKE_O(wake), .PORT_A_PULL_HIGH_O(pull));
	tsiu_core_model #(.DEPTH(2)) tsiu_core_model_i (
		.clk_i(clk), .reset_n_i(rst_n), .push_i(push), .ret_i(ret), .phase_o(phase), .full_o(full));
	// ****************
	// helpers
	// ****************
	function automatic logic [7:0] rnd();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 64) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		int n;
		bit ga, gw;
		ga = 0;
		gw = 0;
		awaddr <= a;
		wdata <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		for (n = 0; n < 64 && !(ga && gw); n++) begin
			@(posedge clk);
			if (awr === 1'h1 && !ga) begin
				ga = 1;
				awv <= 1'h0;
			end
			if (wrdy === 1'h1 && !gw) begin
				gw = 1;
				wv <= 1'h0;
			end
		end
		tmo(n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (bv !== 1'h1 && n < 64);
		tmo(n);
		// bready stays high, so a following write never drops and raises it in one step
		r = bresp;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (arr !== 1'h1 && n < 64);
		tmo(n);
		arv <= 1'h0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rv !== 1'h1 && n < 64);
		tmo(n);
		d = rdata;
		r = rresp;
	endtask
	task automatic w(input logic [31:0] a, d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", r, 2'h0);
	endtask
	task automatic rchk(input logic [31:0] a, exp, input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, d, exp);
	endtask
	// entry may come at once, so the current cycle is looked at first
	task automatic ent(input logic on, input logic [7:0] v);
		int n;
		logic seen;
		seen = 1'h0;
		for (n = 0; n < 16 && !seen; n++) begin
			#1;
			seen = ent_o === 1'h1;
			if (seen) begin
				chk("vector", vec, v);
				chk("push", push, 1'h1);
			end else
				@(posedge clk);
		end
		// back onto an edge, so the next stimulus starts there
		if (seen) begin
			@(posedge clk);
		end
		chk("entry", seen, on);
	endtask
	task automatic ev(input int s);
		if (s == 0) pin <= 1'h0;
		else if (s == 1) tov <= 1'h1;
		else cdn <= 1'h1;
		@(posedge clk);
		tov <= 1'h0;
		cdn <= 1'h0;
		@(posedge clk);
		pin <= 1'h1;
	endtask
	task automatic pop();
		ret <= 1'h1;
		@(posedge clk);
		ret <= 1'h0;
		@(posedge clk);
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		logic [31:0] a, d;
		logic [1:0]  r;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rchk(CT, 32'h0, "ctrl reset");
		rchk(CO, 32'h1, "core reset");
		chk("pull reset", pull, 1'h0);
		$display("test reset done");
		for (int s = 0; s < 3; s++) begin
			w(CT, 32'h2 << s);
			repeat (rnd() % 8) @(posedge clk);
			ev(s);
			ent(1'h0, 8'h0);
			rchk(CT, 32'h12 << s, "flag set");
			w(CT, (32'h12 << s) | 32'h1);
			ent(1'h1, vtab[s]);
			rchk(CT, 32'h2 << s, "flag gie clear");
			pop();
		end
		$display("test sources done");
		w(CT, 32'he);
		ev(0);
		ev(1);
		ev(2);
		rchk(CT, 32'h7e, "all flags");
		w(CT, 32'h7f);
		ent(1'h1, vtab[0]);
		rchk(CT, 32'h6e, "after ext");
		w(CT, 32'h6f);
		ent(1'h1, vtab[1]);
		w(CT, 32'h4f);
		ent(1'h0, 8'h0);
		pop();
		ent(1'h1, vtab[2]);
		pop();
		pop();
		$display("test priority done");
		pdn <= 1'h1;
		for (int s = 0; s < 3; s++) begin
			w(CT, 32'h12 << s);
			repeat (2) @(posedge clk);
			chk("wake", wake, 1'h1);
			w(CT, (32'h2 << s) | 32'h1);
			ent(1'h0, 8'h0);
			chk("wake off", wake, 1'h0);
		end
		pdn <= 1'h0;
		w(CT, 32'h0);
		$display("test wake done");
		w(CO, 32'h2);
		w(CT, 32'h2);
		ev(0);
		rchk(CT, 32'h2, "pin output");
		chk("pull", pull, 1'h1);
		w(CO, 32'h3);
		ev(0);
		rchk(CT, 32'h12, "pin input");
		a = 32'hc + {22'h0, rnd(), 2'h0};
		wr(a, {4{rnd()}}, r);
		chk("unmapped bresp", r, 2'h2);
		rd(a, d, r);
		chk("unmapped rresp", r, 2'h2);
		chk("unmapped rdata", d, 32'h0);
		rchk(CT, 32'h12, "ctrl kept");
		$display("test pin and bus done");
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rchk(CT, 32'h0, "ctrl rereset");
		$display("test rereset done");
		complete_run();
	end
endmodule // tsiu_top_bench
`default_nettype wire
